// file: hw/aigc_bus.sv
// AHB-Lite slave front end with one wait state per word-size NONSEQ transfer; other transfers get none
`timescale 1ns/100ps
module aigc_bus (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output      logic [31:0] hrdata,
  output      logic        hreadyout,
  output      logic        hresp,
  aigc_reg_if.bus          rif
);
  import aigc_pkg::*;

  typedef struct packed {
    logic        pend;
    logic        write;
    logic [7:0]  addr;
    logic        rdy;
    logic        resp;
    logic [31:0] rdata;
  } aigc_bus_st_t;

  aigc_bus_st_t st_r;
  aigc_bus_st_t st_nxt;

  // The wait state lets read data leave straight from a flop
  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.pend = 1'b0;
    st_nxt.rdy  = 1'b1;
    if (st_r.pend)
      st_nxt.rdata = rif.rdata;
    if (hsel && hready && htrans == HTRANS_NONSEQ && hsize == HSIZE_WORD)
    begin
      st_nxt.pend  = 1'b1;
      st_nxt.write = hwrite;
      st_nxt.addr  = haddr[7:0];
      st_nxt.rdy   = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st_r <= '{rdy: 1'b1, default: '0};
    else
      st_r <= st_nxt;
  end

  assign rif.wr    = st_r.pend && st_r.write;
  assign rif.rd    = st_r.pend && !st_r.write;
  assign rif.addr  = st_r.addr;
  assign rif.wdata = hwdata;
  assign hrdata    = st_r.rdata;
  assign hreadyout = st_r.rdy;
  assign hresp     = st_r.resp;
endmodule

// file: hw/aigc_timer.sv
// Standby timer with its one-second divider
`timescale 1ns/100ps
module aigc_timer #(
  parameter int unsigned TICK_CYCLES = aigc_pkg::SEC_CYCLES
)(
  input  wire logic hclk,
  input  wire logic hresetn,
  aigc_tmr_if.tmr   tif
);
  import aigc_pkg::*;

  localparam int DW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

  if (TICK_CYCLES < 1)
    $error("TICK_CYCLES must be at least one");

  typedef struct packed {
    logic [DW-1:0]     div;
    logic              on;
    logic              fired;
    logic [SECS_W-1:0] period;
    logic [SECS_W-1:0] left;
  } aigc_tmr_st_t;

  aigc_tmr_st_t st_r;
  aigc_tmr_st_t st_nxt;
  logic         tick;

  function automatic logic [SECS_W-1:0] period_of(input logic [7:0] code);
    logic [SECS_W-1:0] p;
    p = '0;
    if (code >= TMO_SEC_FIRST && code <= TMO_SEC_LAST)
      p = SECS_W'(code * SEC_STEP);
    else if (code >= TMO_HH_FIRST && code <= TMO_HH_LAST)
      p = SECS_W'((code - HH_BASE) * HH_SECS);
    else if (code == TMO_21M)
      p = T21M_SECS;
    else if (code == TMO_8H)
      p = T8H_SECS;
    else if (code == TMO_21M15)
      p = T21M15_SECS;
    return p;
  endfunction

  always_comb
  begin
    st_nxt       = st_r;
    st_nxt.fired = 1'b0;
    tick         = (st_r.div == DW'(TICK_CYCLES - 1));
    st_nxt.div   = tick ? '0 : st_r.div + 1'b1;
    if (tif.load)
    begin
      // Reserved code FEh is taken as off, like zero
      st_nxt.on     = (tif.code != TMO_OFF) && (tif.code != TMO_RSVD);
      st_nxt.period = period_of(tif.code);
      st_nxt.left   = period_of(tif.code);
      st_nxt.div    = '0;
    end
    else if (tif.restart && st_r.on)
    begin
      st_nxt.left = st_r.period;
      st_nxt.div  = '0;
    end
    else if (st_r.on && tick && st_r.left != '0)
    begin
      st_nxt.left  = st_r.left - 1'b1;
      st_nxt.fired = (st_r.left == SECS_W'(1));
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign tif.enabled = st_r.on;
  assign tif.expired = st_r.fired;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  period_sec_a: assert property (
    (tif.load && tif.code >= TMO_SEC_FIRST && tif.code <= TMO_SEC_LAST)
      |=> st_r.on && st_r.period == SECS_W'($past(tif.code) * SEC_STEP))
    else $error("seconds code gave a wrong standby period");
  period_8h_a: assert property (
    (tif.load && tif.code == TMO_8H) |=> st_r.on && st_r.period == T8H_SECS)
    else $error("eight hour code gave a wrong standby period");
  restart_a: assert property (
    (tif.restart && st_r.on && !tif.load) |=> st_r.left == st_r.period)
    else $error("command did not restart the standby timer");
endmodule

// file: hw/aigc_top.sv
// Command core for Idle, Idle Immediate and Initialize Device Parameters
`timescale 1ns/100ps
module aigc_top #(
  parameter int unsigned TICK_CYCLES = aigc_pkg::SEC_CYCLES,
  parameter logic [7:0]  MAX_SPT     = aigc_pkg::DEF_SPT
)(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output      logic [31:0] hrdata,
  output      logic        hreadyout,
  output      logic        hresp,
  input  wire logic        drive_fault,
  output      logic        intrq,
  output      logic        idle_mode,
  output      logic        standby_mode,
  output      logic        media_go
);
  import aigc_pkg::*;

  if (MAX_SPT == '0)
    $error("MAX_SPT must be nonzero");

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    aigc_cmd_state_t cs;
    logic [7:0]      err;
    logic [7:0]      sect;
    logic [7:0]      devhead;
    logic [7:0]      cmd;
    logic            bsy;
    logic            drdy;
    logic            df;
    logic            errb;
    logic [7:0]      spt;
    logic [3:0]      maxhead;
    logic            geom_ok;
    logic            intrq;
    logic            idle;
    logic            standby;
    logic            media_go;
  } aigc_top_st_t;

  localparam aigc_top_st_t ST_RESET = '{
    cs:      CS_READY,
    drdy:    1'b1,
    spt:     DEF_SPT,
    maxhead: DEF_MAXHEAD,
    geom_ok: 1'b1,
    default: '0
  };

  aigc_top_st_t st_r;
  aigc_top_st_t st_nxt;
  logic [7:0]   status_b;
  logic [7:0]   fail_mask;
  logic         cmd_take;

  aigc_reg_if rif ();
  aigc_tmr_if tif ();

  // ----------------------------------------------------------------
  // Bus slave and standby timer
  // ----------------------------------------------------------------
  aigc_bus u_bus (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .rif       (rif.bus)
  );

  aigc_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tif     (tif.tmr)
  );

  // ----------------------------------------------------------------
  // Register file and command engine
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt          = st_r;
    st_nxt.media_go = 1'b0;
    tif.load        = 1'b0;
    tif.code        = st_r.sect;
    tif.restart     = 1'b0;
    fail_mask       = '0;
    cmd_take        = rif.wr && !st_r.bsy && rif.addr == ADDR_CMD;

    // DRQ never rises: none of these commands moves data
    status_b          = '0;
    status_b[ST_BSY]  = st_r.bsy;
    status_b[ST_DRDY] = st_r.drdy;
    status_b[ST_DF]   = st_r.df;
    status_b[ST_ERR]  = st_r.errb;

    rif.rdata = '0;
    case (rif.addr)
      ADDR_ERROR:   rif.rdata[7:0] = st_r.err;
      ADDR_SECT:    rif.rdata[7:0] = st_r.sect;
      ADDR_DEVHEAD: rif.rdata[7:0] = st_r.devhead;
      ADDR_STATUS:  rif.rdata[7:0] = status_b;
      ADDR_GEOM:
      begin
        rif.rdata[7:0]                  = st_r.spt;
        rif.rdata[GEOM_HEAD_LSB +: 4]   = st_r.maxhead;
        rif.rdata[GEOM_OK_BIT]          = st_r.geom_ok;
      end
      ADDR_POWER:
      begin
        rif.rdata[PWR_IDLE_BIT] = st_r.idle;
        rif.rdata[PWR_STBY_BIT] = st_r.standby;
        rif.rdata[PWR_TMR_BIT]  = tif.enabled;
      end
      default:      rif.rdata = '0;
    endcase

    // Reading status acknowledges the interrupt
    if (rif.rd && rif.addr == ADDR_STATUS)
      st_nxt.intrq = 1'b0;

    if (tif.expired)
    begin
      st_nxt.standby = 1'b1;
      st_nxt.idle    = 1'b0;
    end

    // Writes while busy are dropped so a running command keeps its inputs
    if (rif.wr && !st_r.bsy)
    begin
      if (rif.addr == ADDR_SECT)
        st_nxt.sect = rif.wdata[7:0];
      if (rif.addr == ADDR_DEVHEAD)
        st_nxt.devhead = rif.wdata[7:0];
    end

    // No ready check on command entry, so Init Params always runs
    if (cmd_take)
    begin
      st_nxt.cmd   = rif.wdata[7:0];
      st_nxt.bsy   = 1'b1;
      st_nxt.cs    = CS_EXEC;
      st_nxt.intrq = 1'b0;
      tif.restart  = 1'b1;
    end

    unique case (st_r.cs)
      CS_READY:
      begin
        fail_mask = '0;
      end
      CS_EXEC:
      begin
        unique case (st_r.cmd)
          CMD_IDLE:
          begin
            tif.load       = 1'b1;
            st_nxt.idle    = 1'b1;
            st_nxt.standby = 1'b0;
          end
          CMD_IDLE_IMM:
          begin
            st_nxt.idle    = 1'b1;
            st_nxt.standby = 1'b0;
          end
          CMD_INIT_PARAMS:
          begin
            st_nxt.spt     = st_r.sect;
            st_nxt.maxhead = st_r.devhead[DH_HEAD_MSB:0];
            st_nxt.geom_ok = (st_r.sect != '0) && (st_r.sect <= MAX_SPT);
          end
          CMD_READ_MULT:
          begin
            if (st_r.geom_ok)
              st_nxt.media_go = 1'b1;
            else
              fail_mask[ER_IDNF_BIT] = 1'b1;
          end
          default:
          begin
            fail_mask[ER_ABRT_BIT] = 1'b1;
          end
        endcase
        // Interrupt goes out now, on the same edge as the idle mode change
        st_nxt.cs    = CS_READY;
        st_nxt.bsy   = 1'b0;
        st_nxt.drdy  = 1'b1;
        st_nxt.intrq = 1'b1;
        st_nxt.err   = fail_mask;
        st_nxt.errb  = (fail_mask != '0);
        if (fail_mask != '0)
          st_nxt.df = drive_fault;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st_r <= ST_RESET;
    else
      st_r <= st_nxt;
  end

  assign intrq        = st_r.intrq;
  assign idle_mode    = st_r.idle;
  assign standby_mode = st_r.standby;
  assign media_go     = st_r.media_go;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_cmd(logic [7:0] code);
    cmd_take && rif.wdata[7:0] == code;
  endsequence

  sequence s_done_ok;
    !st_r.bsy && st_r.drdy && !st_r.errb && st_r.intrq;
  endsequence

  idle_timer_on_a: assert property (
    (s_cmd(CMD_IDLE) ##0 (st_r.sect != TMO_OFF && st_r.sect != TMO_RSVD))
      |-> ##2 tif.enabled)
    else $error("idle with nonzero count left the timer off");

  idle_timer_off_a: assert property (
    (s_cmd(CMD_IDLE) ##0 st_r.sect == TMO_OFF) |-> ##2 !tif.enabled)
    else $error("idle with zero count left the timer on");

  idle_mode_a: assert property (
    s_cmd(CMD_IDLE) |-> ##1 st_r.bsy ##1 (st_r.idle && !st_r.standby))
    else $error("idle did not enter idle mode");

  imm_keeps_timer_a: assert property (
    s_cmd(CMD_IDLE_IMM) |-> ##1 ($stable(tif.enabled))[*2] ##0 st_r.idle)
    else $error("idle immediate touched the timer or missed idle mode");

  done_intrq_a: assert property (
    cmd_take |-> ##2 (st_r.intrq && !st_r.bsy))
    else $error("command finished without raising the interrupt");

  ok_status_a: assert property (
    (s_cmd(CMD_IDLE) or s_cmd(CMD_IDLE_IMM)) |-> ##2 s_done_ok)
    else $error("idle command ended with a wrong status");

  abort_status_a: assert property (
    s_cmd(CMD_NOP) |-> ##2 (st_r.err[ER_ABRT_BIT] && !st_r.bsy && st_r.drdy))
    else $error("unsupported command was not aborted");

  df_on_fault_a: assert property (
    (st_r.cs == CS_EXEC && fail_mask != '0 && drive_fault) |=> st_r.df)
    else $error("drive fault missing from failed command status");

  err_summary_a: assert property (
    st_r.errb == (st_r.err != '0))
    else $error("status error bit disagrees with the error register");

  geom_load_a: assert property (
    s_cmd(CMD_INIT_PARAMS) |-> ##2
      (st_r.spt == st_r.sect && st_r.maxhead == st_r.devhead[DH_HEAD_MSB:0]))
    else $error("init params did not store the geometry");

  idnf_a: assert property (
    (s_cmd(CMD_READ_MULT) ##0 !st_r.geom_ok)
      |-> ##2 (st_r.err[ER_IDNF_BIT] && st_r.errb && !st_r.media_go))
    else $error("media access with bad geometry was not refused");

  init_any_time_a: assert property (
    s_cmd(CMD_INIT_PARAMS) ##0 !st_r.sect[7] |-> ##2 (!st_r.bsy && st_r.intrq))
    else $error("init params did not complete");

  sequence s_busy_then_done;
    st_r.bsy ##1 !st_r.bsy;
  endsequence

  busy_one_cycle_a: assert property (
    cmd_take |=> s_busy_then_done)
    else $error("busy did not last exactly one cycle");

  media_pulse_a: assert property (
    (s_cmd(CMD_READ_MULT) ##0 st_r.geom_ok) |-> ##2 st_r.media_go ##1 !st_r.media_go)
    else $error("media access with good geometry gave no single pulse");

  bad_geom_a: assert property (
    (s_cmd(CMD_INIT_PARAMS) ##0 st_r.sect > MAX_SPT)
      |-> ##2 (!st_r.geom_ok && !st_r.errb && !st_r.bsy))
    else $error("init params accepted an unsupported geometry");

  no_fault_df_a: assert property (
    (st_r.cs == CS_EXEC && fail_mask != '0 && !drive_fault) |=> !st_r.df)
    else $error("drive fault shown without a fault present");

  expiry_standby_a: assert property (
    (tif.expired && st_r.cs == CS_READY) |=> (st_r.standby && !st_r.idle))
    else $error("timer expiry did not move the drive to standby");

  intrq_ack_a: assert property (
    (rif.rd && rif.addr == ADDR_STATUS && st_r.cs == CS_READY) |=> !st_r.intrq)
    else $error("status read did not acknowledge the interrupt");

  // Read data leaves a flop, so every word-size NONSEQ access costs exactly one wait state; other transfers are ignored with none
  wait_state_a: assert property (
    (hsel && hready && htrans == HTRANS_NONSEQ && hsize == HSIZE_WORD)
      |=> !hreadyout ##1 hreadyout)
    else $error("register access did not take exactly one wait state");
endmodule

// file: include/aigc_if.sv
// Interfaces between the command core, its bus slave and its standby timer
`timescale 1ns/100ps
interface aigc_reg_if;
  logic        wr;
  logic        rd;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport bus  (output wr, rd, addr, wdata, input rdata);
  modport regs (input wr, rd, addr, wdata, output rdata);
endinterface

interface aigc_tmr_if;
  logic       load;
  logic [7:0] code;
  logic       restart;
  logic       enabled;
  logic       expired;
  modport ctl (output load, code, restart, input enabled, expired);
  modport tmr (input load, code, restart, output enabled, expired);
endinterface

// file: include/aigc_pkg.sv
// Constants and types shared by the ATA idle and geometry command block
// ----------------------------------------------------------------------
// Operation
// - Idle with nonzero count enables standby timer with the encoded period; here reserved FEh leaves it off
// - Idle with count zero disables the standby timer
// - Codes 01h-F0h give code*5 s; F1h-FBh give (code-240)*30 min
// - FCh gives 21 min, FDh 8 h, FFh 21 min 15 s; FEh reserved
// - Idle enters Idle mode while it programs the timer
// - Idle Immediate enters Idle mode, timer setting and enable untouched
// - Both idle commands raise INTRQ at completion, before idle settles; here idle is set on the same edge as INTRQ
// - Idle success clears BSY, sets DRDY, clears ERR
// - Failure sets ABRT (error bit 2), clears BSY and DRQ, sets DRDY
// - Error path sets DF when a drive fault is present
// - Error path sets ERR whenever any error bit is set
// - Init Params takes sector count as logical sectors per track
// - Init Params takes device/head low bits as maximum head number
// - Stored maximum head is logical heads minus one for CHS
// - Unsupported geometry fails media access with ID not found
// ----------------------------------------------------------------------
package aigc_pkg;
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned SEC_NS        = 1_000_000_000;
  localparam int unsigned SEC_CYCLES    = SEC_NS / CLK_PERIOD_NS;
  // Register byte offsets
  localparam logic [7:0] ADDR_ERROR   = 8'h00;
  localparam logic [7:0] ADDR_SECT    = 8'h04;
  localparam logic [7:0] ADDR_DEVHEAD = 8'h08;
  localparam logic [7:0] ADDR_CMD     = 8'h0C;
  localparam logic [7:0] ADDR_STATUS  = 8'h10;
  localparam logic [7:0] ADDR_GEOM    = 8'h14;
  localparam logic [7:0] ADDR_POWER   = 8'h18;
  // Field positions
  localparam int ST_BSY = 7;
  localparam int ST_DRDY = 6;
  localparam int ST_DF = 5;
  localparam int ST_ERR = 0;
  localparam int ER_ABRT_BIT = 2;
  localparam int ER_IDNF_BIT = 4;
  localparam int DH_HEAD_MSB = 3;
  localparam int GEOM_HEAD_LSB = 8;
  localparam int GEOM_OK_BIT = 16;
  localparam int PWR_IDLE_BIT = 0;
  localparam int PWR_STBY_BIT = 1;
  localparam int PWR_TMR_BIT = 2;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  // Command codes
  localparam logic [7:0] CMD_IDLE        = 8'hE3;
  localparam logic [7:0] CMD_IDLE_IMM    = 8'hE1;
  localparam logic [7:0] CMD_INIT_PARAMS = 8'h91;
  localparam logic [7:0] CMD_READ_MULT   = 8'hC4;
  localparam logic [7:0] CMD_NOP         = 8'h00;
  // Standby period codes and their lengths in seconds
  localparam int SECS_W = 15;
  localparam logic [7:0] TMO_OFF       = 8'h00;
  localparam logic [7:0] TMO_SEC_FIRST = 8'h01;
  localparam logic [7:0] TMO_SEC_LAST  = 8'hF0;
  localparam logic [7:0] TMO_HH_FIRST  = 8'hF1;
  localparam logic [7:0] TMO_HH_LAST   = 8'hFB;
  localparam logic [7:0] TMO_21M       = 8'hFC;
  localparam logic [7:0] TMO_8H        = 8'hFD;
  localparam logic [7:0] TMO_RSVD      = 8'hFE;
  localparam logic [7:0] TMO_21M15     = 8'hFF;
  localparam int unsigned SEC_STEP = 5;
  localparam int unsigned HH_BASE  = 240;
  localparam int unsigned HH_SECS  = 30 * 60;
  localparam logic [SECS_W-1:0] T21M_SECS   = 15'(21 * 60);
  localparam logic [SECS_W-1:0] T8H_SECS    = 15'(8 * 3600);
  localparam logic [SECS_W-1:0] T21M15_SECS = 15'(21 * 60 + 15);
  // Default translation
  localparam logic [7:0] DEF_SPT     = 8'h3F;
  localparam logic [3:0] DEF_MAXHEAD = 4'hF;
  typedef enum logic [0:0] {CS_READY, CS_EXEC} aigc_cmd_state_t;
endpackage

// file: sim/aigc_host.sv
// Host model: AHB-Lite master issuing task-file accesses and commands
`timescale 1ns/100ps
module aigc_host (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output      logic        hsel,
  output      logic [31:0] haddr,
  output      logic [1:0]  htrans,
  output      logic        hwrite,
  output      logic [2:0]  hsize,
  output      logic [31:0] hwdata
);
  import aigc_pkg::*;
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0;
  end
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize  <= HSIZE_WORD;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    // Released data bus must not keep showing the last word
    hwdata <= ~wd;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] x;
    xfer(1'b1, a, {24'h000000, d}, x);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    xfer(1'b0, a, 32'h0, d);
  endtask
  task automatic cmd(input logic [7:0] c, input logic [7:0] sc, input logic [3:0] head);
    logic [31:0] s;
    do rd(ADDR_STATUS, s); while (s[ST_DRDY] !== 1'b1);
    wr(ADDR_SECT, sc);
    wr(ADDR_DEVHEAD, {4'hA, head});
    wr(ADDR_CMD, c);
  endtask
endmodule

// file: sim/aigc_top_tb.sv
// Self-checking bench for the idle and geometry command block
`timescale 1ns/100ps
module aigc_top_tb;
  import aigc_pkg::*;
  localparam int unsigned TICK    = 4;
  localparam logic [7:0]  SPT_MAX = 8'h3F;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        drive_fault, intrq, idle_mode, standby_mode, media_go;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          fails, check_count, go_count, g0;
  time         t_mark;
  aigc_top #(.TICK_CYCLES(TICK), .MAX_SPT(SPT_MAX)) i_aigc_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .drive_fault(drive_fault), .intrq(intrq), .idle_mode(idle_mode),
    .standby_mode(standby_mode), .media_go(media_go));
  aigc_host i_aigc_host (
    .hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  always @(posedge hclk)
    if (media_go === 1'b1)
      go_count <= go_count + 1;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkreg(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    i_aigc_host.rd(a, r);
    chk(r, exp);
  endtask
  task automatic done(input logic [7:0] st, input logic [7:0] er);
    @(negedge hclk);
    t_mark = $time;
    chk({31'h0, intrq}, 32'h1);
    chkreg(ADDR_STATUS, {24'h0, st});
    chk({31'h0, intrq}, 32'h0);
    chkreg(ADDR_ERROR, {24'h0, er});
  endtask
  // Standby is timed from the negedge after completion, so bus traffic does not blur it
  task automatic wait_stby(input int lim);
    int n;
    n = 0;
    while (standby_mode !== 1'b1 && n < lim + 20)
    begin
      @(posedge hclk);
      n++;
    end
    n = int'(($time - t_mark) / CLK_PERIOD_NS);
    chk({31'h0, (n >= lim && n <= lim + 1)}, 32'h1);
  endtask
  task automatic end_of_test;
    $display("Counts: checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chkreg(ADDR_STATUS, 32'h40);
    chkreg(ADDR_ERROR, 32'h0);
    chkreg(ADDR_GEOM, 32'h0001_0F3F);
    chkreg(ADDR_POWER, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    i_aigc_host.wr(ADDR_SECT, 8'h5A);
    chkreg(ADDR_SECT, 32'h5A);
    i_aigc_host.wr(8'h1C, 8'hFF);
    chkreg(8'h1C, 32'h0);
    chkreg(ADDR_CMD, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_timer;
    logic [7:0]  code [6] = '{8'h01, 8'h02, 8'hF0, 8'hF1, 8'hFC, 8'hFF};
    int unsigned secs [6] = '{5, 10, 1200, 1800, 1260, 1275};
    for (int k = 0; k < 6; k++)
    begin
      i_aigc_host.cmd(CMD_IDLE, code[k], 4'h0);
      done(8'h40, 8'h00);
      chk({31'h0, idle_mode}, 32'h1);
      chkreg(ADDR_POWER, 32'h5);
      wait_stby(secs[k] * TICK);
      @(negedge hclk);
      chk({31'h0, idle_mode}, 32'h0);
    end
    i_aigc_host.cmd(CMD_IDLE, TMO_8H, 4'h0);
    done(8'h40, 8'h00);
    chkreg(ADDR_POWER, 32'h5);
    i_aigc_host.cmd(CMD_IDLE, TMO_RSVD, 4'h0);
    done(8'h40, 8'h00);
    chkreg(ADDR_POWER, 32'h1);
    $display("timer test done");
  endtask
  task automatic t_idle_imm;
    i_aigc_host.cmd(CMD_IDLE, 8'h02, 4'h0);
    done(8'h40, 8'h00);
    repeat (10) @(posedge hclk);
    // A command write mid-period restarts the full period
    i_aigc_host.cmd(CMD_IDLE_IMM, 8'h00, 4'h0);
    done(8'h40, 8'h00);
    chkreg(ADDR_POWER, 32'h5);
    wait_stby(40);
    i_aigc_host.cmd(CMD_IDLE, TMO_OFF, 4'h0);
    done(8'h40, 8'h00);
    i_aigc_host.cmd(CMD_IDLE_IMM, 8'h01, 4'h0);
    done(8'h40, 8'h00);
    chkreg(ADDR_POWER, 32'h1);
    repeat (80) @(posedge hclk);
    chk({30'h0, standby_mode, idle_mode}, 32'h1);
    $display("idle immediate test done");
  endtask
  task automatic t_errors;
    @(posedge hclk);
    drive_fault <= 1'b1;
    i_aigc_host.cmd(CMD_NOP, 8'h00, 4'h0);
    done(8'h61, 8'h04);
    @(posedge hclk);
    drive_fault <= 1'b0;
    i_aigc_host.cmd(8'hAA, 8'h00, 4'h0);
    done(8'h41, 8'h04);
    i_aigc_host.cmd(CMD_IDLE, TMO_OFF, 4'h0);
    done(8'h40, 8'h00);
    $display("error test done");
  endtask
  task automatic t_geometry;
    i_aigc_host.cmd(CMD_INIT_PARAMS, 8'h20, 4'h5);
    done(8'h40, 8'h00);
    chkreg(ADDR_GEOM, 32'h0001_0520);
    g0 = go_count;
    i_aigc_host.cmd(CMD_READ_MULT, 8'h01, 4'h0);
    done(8'h40, 8'h00);
    chk(go_count - g0, 32'h1);
    i_aigc_host.cmd(CMD_INIT_PARAMS, SPT_MAX + 8'h01, 4'h3);
    done(8'h40, 8'h00);
    chkreg(ADDR_GEOM, 32'h0000_0340);
    g0 = go_count;
    i_aigc_host.cmd(CMD_READ_MULT, 8'h01, 4'h0);
    done(8'h41, 8'h10);
    chk(go_count - g0, 32'h0);
    i_aigc_host.cmd(CMD_INIT_PARAMS, SPT_MAX, 4'hF);
    done(8'h40, 8'h00);
    chkreg(ADDR_GEOM, 32'h0001_0F3F);
    i_aigc_host.cmd(CMD_READ_MULT, 8'h01, 4'h0);
    done(8'h40, 8'h00);
    $display("geometry test done");
  endtask
  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    hresetn = 1'b0;
    drive_fault = 1'b0;
    fails = 0;
    check_count = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_timer();
    t_idle_imm();
    t_errors();
    t_geometry();
    end_of_test();
  end
  // Longest run is about 22k cycles of timer waits
  initial
  begin
    #(100 * 40000);
    fails++;
    $display("FAIL watchdog t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
    end_of_test();
  end
endmodule
